// ===== core/abc_burst_ctrl.sv
// Burst ADC output sequencer, decimator and serial register port
`timescale 1ns/1ps
// Overview of operation
// - Sleep selection applies only while enable low
// - Alternate 2^N hires, 2^(N+3) lowres
// - Startup 2^13 lowres, triggers ignored
// - New N applied at cycle start
// - N resets to 10, range 10..25
// - Receive filter low-pass or high-pass
// - Manual mode raises ready after lowres
// - Rising trigger while ready starts burst
// - Hires begins 2-3 clocks, flag exact
// - After hires reread N, lockout lowres
// - Ready rises with last lockout sample
// - Auto mode runs hires without trigger
// - Auto ignores trigger, ready one pulse
// - Three-wire default, four-wire via bit
// - Rw bit, seven address bits, sixteen data bits
// - First edge after select captures rw
// - Write: address then data, rising edges
// - Read shifts sixteen bits MSB first
// - Read bit blocks writes until cleared
// - Hardware reset restores all defaults
// - Mode bit two selects auto trigger
// - Burst field bits 13..10 give N-10
// - Key to 0x2C resets registers
module abc_burst_ctrl
  import abc_pkg::*;
(
  input  wire logic        clk,               // Converter sample clock
  input  wire logic        rst_n,             // Sync reset, active low
  input  wire logic        hardware_reset_n,  // Reset pin, active low
  input  wire logic        enable_pin,        // Sleep control pin
  input  wire logic        trigger_in,        // External trigger pin
  input  wire logic [11:0] adc_sample,        // Converter sample word
  input  wire logic        serial_select_n,   // Serial select, low
  input  wire logic        serial_clk,        // Serial clock pin
  input  wire logic        serial_data_in,    // Data pin input side
  output logic             serial_data_out,   // Data pin output side
  output logic             serial_data_oe,    // Data pin drive enable
  output logic             serial_read_out,   // Four-wire read pin
  output logic [11:0]      sample_output_bus, // Output data word
  output logic             output_data_clock, // Forwarded data clock
  output logic             trigger_ready_flag,   // Trigger ready
  output logic             high_resolution_flag, // Hires flag
  output logic [5:0]       sleep_mode_active,    // Active sleep code
  output logic             offset_loop_restart   // Offset loop clear
);

  // Synchronisers for pins
  logic [1:0] s_sel_q, s_sel_d;     // Select sync
  logic [1:0] s_clk_q, s_clk_d;     // Serial clock sync
  logic [1:0] s_din_q, s_din_d;     // Data sync
  logic [1:0] s_trg_q, s_trg_d;     // Trigger sync
  logic [1:0] s_en_q, s_en_d;       // Enable sync
  logic [1:0] s_hrst_q, s_hrst_d;   // Reset pin sync
  logic       sclk_prev_q, sclk_prev_d; // Serial clock history
  logic       trg_prev_q, trg_prev_d;   // Trigger history

  always_comb
  begin
    s_sel_d     = {s_sel_q[0], serial_select_n};
    s_clk_d     = {s_clk_q[0], serial_clk};
    s_din_d     = {s_din_q[0], serial_data_in};
    s_trg_d     = {s_trg_q[0], trigger_in};
    s_en_d      = {s_en_q[0], enable_pin};
    s_hrst_d    = {s_hrst_q[0], hardware_reset_n};
    sclk_prev_d = s_clk_q[1];
    trg_prev_d  = s_trg_q[1];
  end

  // Synchroniser registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_sel_q     <= 2'h3;
      s_clk_q     <= 2'h0;
      s_din_q     <= 2'h0;
      s_trg_q     <= 2'h0;
      s_en_q      <= 2'h3;
      s_hrst_q    <= 2'h3;
      sclk_prev_q <= 1'b0;
      trg_prev_q  <= 1'b0;
    end
    else
    begin
      s_sel_q     <= s_sel_d;
      s_clk_q     <= s_clk_d;
      s_din_q     <= s_din_d;
      s_trg_q     <= s_trg_d;
      s_en_q      <= s_en_d;
      s_hrst_q    <= s_hrst_d;
      sclk_prev_q <= sclk_prev_d;
      trg_prev_q  <= trg_prev_d;
    end
  end

  logic sel_act;   // Transfer in progress
  logic sclk_rise; // Serial clock rising
  logic sclk_fall; // Serial clock falling
  logic trg_rise;  // Trigger rising
  logic hw_rst;    // Reset pin asserted
  assign sel_act   = !s_sel_q[1];
  assign sclk_rise = s_clk_q[1] && !sclk_prev_q;
  assign sclk_fall = !s_clk_q[1] && sclk_prev_q;
  assign trg_rise  = s_trg_q[1] && !trg_prev_q;
  assign hw_rst    = !s_hrst_q[1];

  // Register file and serial state
  logic [15:0] r_mode_q, r_mode_d;     // Mode config
  logic [15:0] r_corr_q, r_corr_d;     // Correction/format
  logic [15:0] r_ovr_q, r_ovr_d;       // Over-range threshold
  logic [15:0] r_offs_q, r_offs_d;     // Offset loop control
  logic [15:0] r_synca_q, r_synca_d;   // Sync select A
  logic [15:0] r_syncr_q, r_syncr_d;   // Sync/reference
  logic [15:0] r_trim_q, r_trim_d;     // Performance trim
  logic [15:0] r_burst_q, r_burst_d;   // Burst length
  logic [15:0] r_pdn_q, r_pdn_d;       // Powerdown select
  logic [15:0] r_pbuf_q, r_pbuf_d;     // Power/buffer enables
  logic [15:0] r_drv_q, r_drv_d;       // Output driver
  logic [4:0]  bcnt_q, bcnt_d;         // Bits seen in frame
  logic [22:0] sh_q, sh_d;             // Incoming shift
  logic        rd_q, rd_d;             // Current frame is read
  logic        wlock_q, wlock_d;       // Writes blocked
  logic [15:0] rdsh_q, rdsh_d;         // Read data shifter
  logic        oe_q, oe_d;             // Read phase active
  logic [15:0] rdval;                  // Addressed register value
  logic [6:0]  rd_addr;                // Read address

  // Register read multiplexer
  always_comb
  begin
    rd_addr = {sh_q[5:0], s_din_q[1]};
    unique case (rd_addr)
      REG_MODE_CONFIG:   rdval = r_mode_q;
      REG_CORR_FORMAT:   rdval = r_corr_q;
      REG_OVR_THRESH:    rdval = r_ovr_q;
      REG_OFFSET_LOOP:   rdval = r_offs_q;
      REG_SYNC_SEL_A:    rdval = r_synca_q;
      REG_SYNC_REF_SEL:  rdval = r_syncr_q;
      REG_PERF_TRIM:     rdval = r_trim_q;
      REG_BURST_LENGTH:  rdval = r_burst_q;
      REG_POWERDOWN_SEL: rdval = r_pdn_q;
      REG_POWER_BUF_EN:  rdval = r_pbuf_q;
      REG_OUT_DRIVER:    rdval = r_drv_q;
      default:           rdval = 16'h0000; // Temp, key, unmapped
    endcase
  end

  // Serial frame decode and register writes
  always_comb
  begin
    r_mode_d  = r_mode_q;
    r_corr_d  = r_corr_q;
    r_ovr_d   = r_ovr_q;
    r_offs_d  = r_offs_q;
    r_synca_d = r_synca_q;
    r_syncr_d = r_syncr_q;
    r_trim_d  = r_trim_q;
    r_burst_d = r_burst_q;
    r_pdn_d   = r_pdn_q;
    r_pbuf_d  = r_pbuf_q;
    r_drv_d   = r_drv_q;
    bcnt_d    = bcnt_q;
    sh_d      = sh_q;
    rd_d      = rd_q;
    wlock_d   = wlock_q;
    rdsh_d    = rdsh_q;
    oe_d      = oe_q;
    if (!sel_act)
    begin
      // Idle between frames
      bcnt_d = 5'd0;
      oe_d   = 1'b0;
    end
    else if (sclk_rise && bcnt_q < FRAME_BITS)
    begin
      sh_d   = {sh_q[21:0], s_din_q[1]};
      bcnt_d = bcnt_q + 5'd1;
      if (bcnt_q == 5'd0)
      begin
        rd_d    = s_din_q[1];
        wlock_d = wlock_q || s_din_q[1];
      end
      if (bcnt_q == FRAME_BITS - 5'd1 && !rd_q)
        wlock_d = 1'b0;
      if (bcnt_q == ADDR_BITS - 5'd1)
      begin
        rdsh_d = rdval;
        oe_d   = rd_q;
      end
      if (bcnt_q == FRAME_BITS - 5'd1 && !rd_q && !wlock_q)
      begin
        unique case (sh_q[21:15])
          REG_MODE_CONFIG:   r_mode_d  = {sh_q[14:0], s_din_q[1]};
          REG_CORR_FORMAT:   r_corr_d  = {sh_q[14:0], s_din_q[1]};
          REG_OVR_THRESH:    r_ovr_d   = {sh_q[14:0], s_din_q[1]};
          REG_OFFSET_LOOP:   r_offs_d  = {sh_q[14:0], s_din_q[1]};
          REG_SYNC_SEL_A:    r_synca_d = {sh_q[14:0], s_din_q[1]};
          REG_SYNC_REF_SEL:  r_syncr_d = {sh_q[14:0], s_din_q[1]};
          REG_PERF_TRIM:     r_trim_d  = {sh_q[14:0], s_din_q[1]};
          REG_BURST_LENGTH:  r_burst_d = {sh_q[14:0], s_din_q[1]};
          REG_POWERDOWN_SEL: r_pdn_d   = {sh_q[14:0], s_din_q[1]};
          REG_POWER_BUF_EN:  r_pbuf_d  = {sh_q[14:0], s_din_q[1]};
          REG_OUT_DRIVER:    r_drv_d   = {sh_q[14:0], s_din_q[1]};
          REG_SOFT_RESET:
          begin
            if ({sh_q[14:0], s_din_q[1]} == SOFT_RESET_KEY)
            begin
              r_mode_d  = RST_MODE_CONFIG;
              r_corr_d  = RST_CORR_FORMAT;
              r_ovr_d   = RST_OVR_THRESH;
              r_offs_d  = RST_OFFSET_LOOP;
              r_synca_d = RST_SYNC_SEL_A;
              r_syncr_d = RST_SYNC_REF_SEL;
              r_trim_d  = RST_PERF_TRIM;
              r_burst_d = RST_BURST_LENGTH;
              r_pdn_d   = RST_POWERDOWN_SEL;
              r_pbuf_d  = RST_POWER_BUF_EN;
              r_drv_d   = RST_OUT_DRIVER;
            end
          end
          default: ;                           // Read-only or unmapped
        endcase
      end
    end
    else if (sclk_fall && oe_q && bcnt_q > ADDR_BITS)
    begin
      rdsh_d = {rdsh_q[14:0], 1'b0};           // Next bit, MSB first
    end
  end

  // Register file and serial flops
  always_ff @(posedge clk)
  begin
    if (!rst_n || hw_rst)
    begin
      r_mode_q  <= RST_MODE_CONFIG;
      r_corr_q  <= RST_CORR_FORMAT;
      r_ovr_q   <= RST_OVR_THRESH;
      r_offs_q  <= RST_OFFSET_LOOP;
      r_synca_q <= RST_SYNC_SEL_A;
      r_syncr_q <= RST_SYNC_REF_SEL;
      r_trim_q  <= RST_PERF_TRIM;
      r_burst_q <= RST_BURST_LENGTH;
      r_pdn_q   <= RST_POWERDOWN_SEL;
      r_pbuf_q  <= RST_POWER_BUF_EN;
      r_drv_q   <= RST_OUT_DRIVER;
      bcnt_q    <= 5'd0;
      sh_q      <= 23'h0;
      rd_q      <= 1'b0;
      wlock_q   <= 1'b0;
      rdsh_q    <= 16'h0000;
      oe_q      <= 1'b0;
    end
    else
    begin
      r_mode_q  <= r_mode_d;
      r_corr_q  <= r_corr_d;
      r_ovr_q   <= r_ovr_d;
      r_offs_q  <= r_offs_d;
      r_synca_q <= r_synca_d;
      r_syncr_q <= r_syncr_d;
      r_trim_q  <= r_trim_d;
      r_burst_q <= r_burst_d;
      r_pdn_q   <= r_pdn_d;
      r_pbuf_q  <= r_pbuf_d;
      r_drv_q   <= r_drv_d;
      bcnt_q    <= bcnt_d;
      sh_q      <= sh_d;
      rd_q      <= rd_d;
      wlock_q   <= wlock_d;
      rdsh_q    <= rdsh_d;
      oe_q      <= oe_d;
    end
  end

  // Read data routing by wire mode
  logic four_wire; // Four-wire mode selected
  assign four_wire       = r_mode_q[BIT_FOUR_WIRE];
  assign serial_data_out = rdsh_q[15];
  assign serial_data_oe  = oe_q && !four_wire;
  assign serial_read_out = four_wire ? rdsh_q[15] : 1'b0;
  assign sleep_mode_active = s_en_q[1] ? 6'h00 : r_pdn_q[15:10];
  assign offset_loop_restart = r_offs_q[BIT_OFFSET_RST];

  // Burst sequencer
  abc_state_t  st_q, st_d;       // Sequencer state
  logic [28:0] cnt_q, cnt_d;     // Samples left in phase
  logic [4:0]  n_q, n_d;         // Latched N
  logic        rdy_q, rdy_d;     // Ready flag
  logic        hr_q, hr_d;       // Hires flag
  logic        burst_en;         // Burst mode selected
  logic        auto_mode;        // Auto trigger selected
  logic [4:0]  n_now;            // Current register N
  assign burst_en  = !r_mode_q[BIT_RX_FB_SEL];
  assign auto_mode = r_mode_q[BIT_AUTO_TRIG];
  assign n_now     = N_BASE + {1'b0, r_burst_q[BURST_N_LSB +: 4]};

  // Next state of burst sequencer
  always_comb
  begin
    st_d  = st_q;
    cnt_d = cnt_q;
    n_d   = n_q;
    rdy_d = 1'b0;
    hr_d  = 1'b0;
    unique case (st_q)
      ABC_IDLE:
      begin
        if (burst_en)
        begin
          st_d  = ABC_LOWRES;
          cnt_d = (29'd1 << STARTUP_LOG2) - 29'd1;
        end
      end
      ABC_LOWRES:
      begin
        if (cnt_q == 29'd0)
        begin
          n_d = n_now;
          if (auto_mode)
          begin
            st_d  = ABC_HIRES;
            cnt_d = (29'd1 << n_now) - 29'd1;
            hr_d  = 1'b1;
            rdy_d = 1'b1;
          end
          else
          begin
            st_d  = ABC_ARMED;
            rdy_d = 1'b1;
          end
        end
        else
        begin
          cnt_d = cnt_q - 29'd1;
        end
      end
      ABC_ARMED:
      begin
        rdy_d = 1'b1;
        n_d   = n_now;
        if (auto_mode || (trg_rise && rdy_q))
        begin
          st_d  = ABC_HIRES;
          cnt_d = (29'd1 << n_now) - 29'd1;
          hr_d  = 1'b1;
          rdy_d = auto_mode;
        end
      end
      ABC_HIRES:
      begin
        if (cnt_q == 29'd0)
        begin
          st_d  = ABC_LOWRES;
          cnt_d = (29'd1 << (n_now + 5'd3)) - 29'd1;
        end
        else
        begin
          cnt_d = cnt_q - 29'd1;
          hr_d  = 1'b1;
        end
      end
    endcase
    if (!burst_en)
    begin
      st_d = ABC_IDLE;
      hr_d = 1'b0;
      rdy_d = 1'b0;
    end
  end

  // Receive decimation: average pairs, keep low or high band
  logic [11:0] prev_q, prev_d;   // Previous sample
  logic        ph_q, ph_d;       // Decimation phase
  logic [11:0] out_q, out_d;     // Output data
  logic [12:0] pair_sum;         // Pair sum or difference
  logic        clk_out_q, clk_out_d; // Forwarded clock
  always_comb
  begin
    prev_d    = adc_sample;
    ph_d      = !ph_q;
    clk_out_d = !clk_out_q;
    if (r_mode_q[BIT_HIGH_PASS])
      pair_sum = {1'b0, prev_q} - {1'b0, adc_sample};
    else
      pair_sum = {1'b0, prev_q} + {1'b0, adc_sample};
    out_d = out_q;
    if (!burst_en)
    begin
      if (ph_q)
        out_d = pair_sum[12:1];
    end
    else if (hr_d)
      out_d = adc_sample;
    else if (r_mode_q[BIT_BURST_RATE])
    begin
      if (cnt_q[1:0] == 2'd3)
        out_d = {adc_sample[11:1], 1'b0};                     // 11-bit held
    end
    else
      out_d = {adc_sample[11:5], 5'h00};                      // 7-bit
  end

  // Sequencer and data path flops
  always_ff @(posedge clk)
  begin
    if (!rst_n || hw_rst)
    begin
      st_q      <= ABC_IDLE;
      cnt_q     <= 29'd0;
      n_q       <= N_BASE;
      rdy_q     <= 1'b0;
      hr_q      <= 1'b0;
      prev_q    <= 12'h000;
      ph_q      <= 1'b0;
      out_q     <= 12'h000;
      clk_out_q <= 1'b0;
    end
    else
    begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      n_q       <= n_d;
      rdy_q     <= rdy_d;
      hr_q      <= hr_d;
      prev_q    <= prev_d;
      ph_q      <= ph_d;
      out_q     <= out_d;
      clk_out_q <= clk_out_d;
    end
  end

  assign sample_output_bus    = out_q;
  assign output_data_clock    = clk_out_q;
  assign trigger_ready_flag   = rdy_q;
  assign high_resolution_flag = hr_q;
endmodule

// ===== core/abc_pkg.sv
// Package: register map, field positions, defaults and timing for burst ADC
package abc_pkg;
  // Register indices (7-bit serial address)
  localparam logic [6:0] REG_MODE_CONFIG   = 7'h00;
  localparam logic [6:0] REG_CORR_FORMAT   = 7'h01;
  localparam logic [6:0] REG_OVR_THRESH    = 7'h02;
  localparam logic [6:0] REG_OFFSET_LOOP   = 7'h03;
  localparam logic [6:0] REG_SYNC_SEL_A    = 7'h0E;
  localparam logic [6:0] REG_SYNC_REF_SEL  = 7'h0F;
  localparam logic [6:0] REG_PERF_TRIM     = 7'h1A;
  localparam logic [6:0] REG_TEMP_READING  = 7'h2B;
  localparam logic [6:0] REG_SOFT_RESET    = 7'h2C;
  localparam logic [6:0] REG_BURST_LENGTH  = 7'h34;
  localparam logic [6:0] REG_POWERDOWN_SEL = 7'h37;
  localparam logic [6:0] REG_POWER_BUF_EN  = 7'h38;
  localparam logic [6:0] REG_OUT_DRIVER    = 7'h3A;
  // Field positions
  localparam int BIT_FOUR_WIRE   = 15;
  localparam int BIT_RX_FB_SEL   = 14;
  localparam int BIT_HIGH_PASS   = 12;
  localparam int BIT_BURST_RATE  = 5;
  localparam int BIT_AUTO_TRIG   = 2;
  localparam int BIT_OFFSET_RST  = 14;
  localparam int BURST_N_LSB     = 10;
  // Reset values
  localparam logic [15:0] RST_MODE_CONFIG   = 16'h0000;
  localparam logic [15:0] RST_CORR_FORMAT   = 16'h0000;
  localparam logic [15:0] RST_OVR_THRESH    = 16'h6780;
  localparam logic [15:0] RST_OFFSET_LOOP   = 16'h4B18;
  localparam logic [15:0] RST_SYNC_SEL_A    = 16'hAAA8;
  localparam logic [15:0] RST_SYNC_REF_SEL  = 16'hA000;
  localparam logic [15:0] RST_PERF_TRIM     = 16'h0B18;
  localparam logic [15:0] RST_BURST_LENGTH  = 16'h0000;
  localparam logic [15:0] RST_POWERDOWN_SEL = 16'h0000;
  localparam logic [15:0] RST_POWER_BUF_EN  = 16'hFFFF;
  localparam logic [15:0] RST_OUT_DRIVER    = 16'h0812;
  localparam logic [15:0] SOFT_RESET_KEY    = 16'hD2F0;
  // Burst sequencing
  localparam logic [4:0] N_BASE        = 5'd10;
  localparam logic [4:0] STARTUP_LOG2  = 5'd13;
  // Serial frame lengths
  localparam logic [4:0] FRAME_BITS    = 5'd24;
  localparam logic [4:0] ADDR_BITS     = 5'd8;
  // Sequencer states
  typedef enum logic [1:0]
  {
    ABC_IDLE   = 2'b00,
    ABC_LOWRES = 2'b01,
    ABC_ARMED  = 2'b10,
    ABC_HIRES  = 2'b11
  } abc_state_t;
  // Output sample word with flags
  typedef struct packed
  {
    logic        hires;
    logic        ready;
    logic [11:0] data;
  } abc_sample_t;
endpackage

// ===== tb/abc_burst_checker.sv
// Checker: burst flags, sleep gating and serial pin relations
`timescale 1ns/1ps
module abc_burst_checker
  import abc_pkg::*;
(
  input wire logic       clk,                  // Sample clock
  input wire logic       rst_n,                // Sync reset, low
  input wire logic       enable_pin,           // Sleep pin
  input wire logic       trigger_in,           // Trigger pin
  input wire logic       serial_select_n,      // Serial select, low
  input wire logic       serial_data_oe,       // Data pin drive
  input wire logic       serial_read_out,      // Four-wire read pin
  input wire logic       trigger_ready_flag,   // Ready flag
  input wire logic       high_resolution_flag, // Hires flag
  input wire logic [5:0] sleep_mode_active     // Active sleep code
);
  logic [25:0] hr_run_q, hr_run_d; // Cycles of current hires run
  logic [19:0] lo_run_q, lo_run_d; // Cycles since hires ended
  // Next run lengths
  always_comb
  begin
    hr_run_d = high_resolution_flag ? hr_run_q + 26'h1 : 26'h0;
    lo_run_d = high_resolution_flag ? 20'h0 : lo_run_q + 20'h1;
  end
  // Register run lengths
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      hr_run_q <= 26'h0;
      lo_run_q <= 20'h0;
    end
    else
    begin
      hr_run_q <= hr_run_d;
      lo_run_q <= lo_run_d;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_sleep_gate;
    enable_pin [*4] |-> sleep_mode_active == 6'h00;
  endproperty
  a_sleep_gate: assert property (p_sleep_gate)
    else $error("sleep code while enabled");
  property p_hr_len;
    $fell(high_resolution_flag) |-> hr_run_q >= 26'h400
      && (hr_run_q & (hr_run_q - 26'h1)) == 26'h0;
  endproperty
  a_hr_len: assert property (p_hr_len)
    else $error("bad hires run length");
  property p_low_len;
    $rose(high_resolution_flag) |-> lo_run_q >= 20'h1FFF;
  endproperty
  a_low_len: assert property (p_low_len)
    else $error("lowres phase too short");
  property p_ready_rise;
    $rose(trigger_ready_flag) && !high_resolution_flag
      |-> lo_run_q >= 20'h1F40;
  endproperty
  a_ready_rise: assert property (p_ready_rise)
    else $error("early ready");
  property p_lockout;
    $fell(high_resolution_flag) |-> !trigger_ready_flag [*8];
  endproperty
  a_lockout: assert property (p_lockout)
    else $error("ready in lockout");
  property p_trig;
    $rose(trigger_in) && trigger_ready_flag && !high_resolution_flag
      |-> ##[1:6] high_resolution_flag;
  endproperty
  a_trig: assert property (p_trig)
    else $error("trigger gave no hires");
  property p_auto_pulse;
    $rose(trigger_ready_flag) && high_resolution_flag
      |=> !trigger_ready_flag;
  endproperty
  a_auto_pulse: assert property (p_auto_pulse)
    else $error("long auto ready pulse");
  property p_release;
    serial_select_n [*6] |-> !serial_data_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("pin driven while idle");
  property p_quiet;
    serial_data_oe |-> !serial_read_out;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("both read pins active");
  c_hires: cover property ($rose(high_resolution_flag));
  c_auto: cover property ($rose(trigger_ready_flag)
    && high_resolution_flag);
  c_read: cover property ($rose(serial_data_oe));
  c_sleep: cover property (sleep_mode_active != 6'h00);
endmodule
bind abc_burst_ctrl abc_burst_checker u_chk
(
  .clk(clk),
  .rst_n(rst_n),
  .enable_pin(enable_pin),
  .trigger_in(trigger_in),
  .serial_select_n(serial_select_n),
  .serial_data_oe(serial_data_oe),
  .serial_read_out(serial_read_out),
  .trigger_ready_flag(trigger_ready_flag),
  .high_resolution_flag(high_resolution_flag),
  .sleep_mode_active(sleep_mode_active)
);

// ===== tb/abc_rx_model.sv
// Receiving logic model: captures words, measures hires bursts
`timescale 1ns/1ps
module abc_rx_model
  import abc_pkg::*;
(
  input  wire logic        clk,        // Capture clock
  input  wire logic        rst_n,      // Sync reset, low
  input  wire logic        data_clock, // Forwarded DDR clock
  input  wire abc_sample_t word_in,    // Flags and data
  output logic      [11:0] last_data,  // Last captured data
  output logic      [25:0] hr_len      // Last hires burst length
);
  logic        dclk_q; // Data clock level seen last
  logic [25:0] run_q;  // Words in current burst
  // One word per data clock edge, either polarity
  always_ff @(posedge clk)
  begin
    dclk_q <= data_clock;
    if (!rst_n)
    begin
      run_q  <= 26'h0;
      hr_len <= 26'h0;
    end
    else if (data_clock != dclk_q)
    begin
      last_data <= word_in.data;
      if (word_in.hires)
        run_q <= run_q + 26'h1;
      else if (run_q != 26'h0)
      begin
        hr_len <= run_q;
        run_q  <= 26'h0;
      end
    end
  end
endmodule

// ===== tb/testbench.sv
// Testbench: register port, burst sequencer, receive filter, sleep
`timescale 1ns/1ps
module testbench
  import abc_pkg::*;
;
  typedef struct
  {
    logic [6:0]  a;   // Register index
    logic [15:0] rst; // Value after reset
    logic [15:0] wd;  // Value written
    logic [15:0] ex;  // Value read back
  } abc_row_t;
  logic        clk, rst_n, hw_rst_n, enable, trig, sel_n, sclk, tb_sd;
  logic        alt, four_w;      // Alternating samples, four-wire
  logic [11:0] adc, adc_set;     // Sample word, steady value
  logic        sd_out, sd_oe, ser_out, odc, ready, hires, olr;
  logic [11:0] bus, rx_data;     // Output word, captured word
  logic [5:0]  sleep;            // Active sleep code
  logic [25:0] rx_len;           // Measured burst length
  logic [15:0] rd;               // Read result
  wire         sd_pin;           // Shared data pin level
  int          fails = 0, samples_checked = 0, cyc = 0;
  abc_row_t    rows [8];         // Register cases
  assign sd_pin = sd_oe ? sd_out : tb_sd;
  abc_burst_ctrl dut
  (
    .clk(clk), .rst_n(rst_n), .hardware_reset_n(hw_rst_n),
    .enable_pin(enable), .trigger_in(trig), .adc_sample(adc),
    .serial_select_n(sel_n), .serial_clk(sclk),
    .serial_data_in(sd_pin), .serial_data_out(sd_out),
    .serial_data_oe(sd_oe), .serial_read_out(ser_out),
    .sample_output_bus(bus), .output_data_clock(odc),
    .trigger_ready_flag(ready), .high_resolution_flag(hires),
    .sleep_mode_active(sleep), .offset_loop_restart(olr)
  );
  abc_rx_model u_rx
  (
    .clk(clk), .rst_n(rst_n), .data_clock(odc),
    .word_in({hires, ready, bus}), .last_data(rx_data), .hr_len(rx_len)
  );
  // 40 MHz sample clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Sample source, alternating or steady
  always @(posedge clk)
    adc <= alt ? ((adc == 12'h400) ? 12'h200 : 12'h400) : adc_set;
  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 99000)
    begin
      fails++;
      final_report();
    end
  end
  task automatic chk(input string n, input logic [25:0] s, e);
    samples_checked++;
    if (s !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // One 24-bit frame, serial clock still outside it
  task automatic spi(input logic rw, input logic [6:0] a,
                     input logic [15:0] wd, output logic [15:0] r);
    logic [23:0] f;
    f = {rw, a, wd};
    @(posedge clk) sel_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 23; i >= 0; i--)
    begin
      @(posedge clk) sclk <= 1'b0;
      tb_sd <= f[i];
      repeat (4) @(posedge clk);
      @(negedge clk) r = {r[14:0], four_w ? ser_out : sd_pin};
      @(posedge clk) sclk <= 1'b1;
      repeat (2) @(posedge clk);
    end
    @(posedge clk) sclk <= 1'b0;
    repeat (4) @(posedge clk);
    sel_n <= 1'b1;
    tb_sd <= ~tb_sd;
    repeat (8) @(posedge clk);
  endtask
  // Second frame covers a write lock left by a read
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] x;
    repeat (2) spi(1'b0, a, d, x);
  endtask
  task automatic pulse();
    @(posedge clk) trig <= 1'b1;
    repeat (4) @(posedge clk);
    trig <= 1'b0;
  endtask
  task automatic wait_for(input logic hr, input logic lvl, input int lim);
    for (int n = 0; (hr ? hires : ready) !== lvl && n < lim; n++)
      @(posedge clk);
  endtask
  // Main sequence
  initial
  begin
    rows = '{'{REG_CORR_FORMAT, RST_CORR_FORMAT, 16'h8008, 16'h8008},
             '{REG_OVR_THRESH, RST_OVR_THRESH, 16'h6400, 16'h6400},
             '{REG_OFFSET_LOOP, RST_OFFSET_LOOP, 16'h0B18, 16'h0B18},
             '{REG_SYNC_SEL_A, RST_SYNC_SEL_A, 16'h5554, 16'h5554},
             '{REG_PERF_TRIM, RST_PERF_TRIM, 16'h4B18, 16'h4B18},
             '{REG_TEMP_READING, 16'h0000, 16'hFFFF, 16'h0000},
             '{REG_POWER_BUF_EN, RST_POWER_BUF_EN, 16'hFE0F, 16'hFE0F},
             '{7'h05, 16'h0000, 16'h1234, 16'h0000}};
    {rst_n, hw_rst_n, enable, trig, sel_n, sclk, tb_sd} = 7'b0110100;
    {alt, four_w, adc, adc_set} = {2'b00, 12'hFFF, 12'hFFF};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk("offset restart", 26'(olr), 26'h1);
    pulse();
    repeat (10) @(posedge clk);
    chk("early hires", 26'(hires), 26'h0);
    chk("lowres word", 26'(bus), 26'hFE0);
    foreach (rows[i])
    begin
      spi(1'b1, rows[i].a, 16'h0, rd);
      chk("reset value", 26'(rd), 26'(rows[i].rst));
      wr(rows[i].a, rows[i].wd);
      spi(1'b1, rows[i].a, 16'h0, rd);
      chk("readback", 26'(rd), 26'(rows[i].ex));
    end
    chk("offset loop", 26'(olr), 26'h0);
    wr(REG_SOFT_RESET, SOFT_RESET_KEY);
    spi(1'b1, REG_SOFT_RESET, 16'h0, rd);
    chk("key clear", 26'(rd), 26'h0);
    chk("offset default", 26'(olr), 26'h1);
    spi(1'b0, REG_CORR_FORMAT, 16'h0008, rd);
    spi(1'b1, REG_CORR_FORMAT, 16'h0, rd);
    chk("write lock", 26'(rd), 26'(RST_CORR_FORMAT));
    wr(REG_POWERDOWN_SEL, 16'hD400);
    enable <= 1'b0;
    repeat (6) @(posedge clk);
    chk("sleep code", 26'(sleep), 26'h35);
    enable <= 1'b1;
    repeat (6) @(posedge clk);
    chk("sleep off", 26'(sleep), 26'h0);
    wait_for(1'b0, 1'b1, 9000);
    chk("ready", 26'(ready), 26'h1);
    pulse();
    wait_for(1'b1, 1'b1, 8);
    chk("hires", 26'(hires), 26'h1);
    wr(REG_BURST_LENGTH, 16'h0400);
    chk("hires word", 26'(bus), 26'hFFF);
    wait_for(1'b1, 1'b0, 1100);
    repeat (2) @(posedge clk);
    chk("burst n10", rx_len, 26'h400);
    pulse();
    repeat (10) @(posedge clk);
    chk("lockout", 26'(hires), 26'h0);
    wait_for(1'b0, 1'b1, 17000);
    pulse();
    wait_for(1'b1, 1'b1, 8);
    wr(REG_BURST_LENGTH, 16'h0000);
    wait_for(1'b1, 1'b0, 2100);
    repeat (2) @(posedge clk);
    chk("burst n11", rx_len, 26'h800);
    wr(REG_MODE_CONFIG, 16'h0004);
    pulse();
    repeat (10) @(posedge clk);
    chk("auto ignore", 26'(hires), 26'h0);
    wait_for(1'b1, 1'b1, 17000);
    chk("auto pulse", 26'(ready), 26'h1);
    wait_for(1'b1, 1'b0, 1100);
    repeat (2) @(posedge clk);
    chk("auto burst", rx_len, 26'h400);
    alt <= 1'b1;
    wr(REG_MODE_CONFIG, 16'h4000);
    chk("low-pass", 26'(bus), 26'h300);
    @(posedge clk);
    chk("low-pass next", 26'(bus), 26'h300);
    alt <= 1'b0;
    adc_set <= 12'h400;
    wr(REG_MODE_CONFIG, 16'h5000);
    chk("high-pass", 26'(bus), 26'h0);
    adc_set <= 12'hFFF;
    wr(REG_MODE_CONFIG, 16'h0020);
    chk("lowres 11", 26'(rx_data), 26'hFFE);
    wr(REG_MODE_CONFIG, 16'h8020);
    four_w = 1'b1;
    spi(1'b1, REG_MODE_CONFIG, 16'h0, rd);
    chk("four-wire", 26'(rd), 26'h8020);
    hw_rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    hw_rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    four_w = 1'b0;
    spi(1'b1, REG_MODE_CONFIG, 16'h0, rd);
    chk("pin reset", 26'(rd), 26'h0);
    chk("pin reset olr", 26'(olr), 26'h1);
    final_report();
  end
endmodule
